// file: core/tmr2_counter.sv
// timer 2 capture/reload counter with its special function registers
`timescale 1ns/100ps
`default_nettype none
`include "tmr2_params.svh"
// What this block does
// - overflow sets control bit 7, software clears
// - no overflow flag while baud select set
// - trigger capture or reload sets bit 6
// - external flag requests interrupt when enabled
// - up/down mode blocks external flag interrupt
// - receive baud from overflow when bit 5
// - transmit baud from overflow when bit 4
// - trigger enable bit 3, not when baud
// - run bit 2 starts, halts, keeps count
// - source select: internal tick or pin edges
// - capture select copies count on trigger
// - reload on overflow and on trigger when capture select clear
// - baud mode forces auto-reload on overflow
// - capture/reload is a 16-bit byte pair
// - control resets zero, bit addressable
// - trigger pin and count pin inputs
module tmr2_counter #(
   parameter int TICK_DIV = `TMR2_TICK_DIV
) (
   input wire logic clk,
   input wire logic srst,
   input wire tmr2_pkg::tmr2_sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   output logic sfr_hit,
   input wire logic timer_irq_enable,
   input wire logic timer1_overflow,
   input wire logic count_pin,
   input wire logic trigger_pin,
   output tmr2_pkg::tmr2_evt_t evt
);
   // =============================================================
   // registers
   logic [7:0] timer_control;
   logic [7:0] timer_mode;
   logic [7:0] capture_reload_low;
   logic [7:0] capture_reload_high;
   logic [7:0] count_low;
   logic [7:0] count_high;
   logic [7:0] next_control;
   logic [7:0] next_mode;
   logic [7:0] next_cap_low;
   logic [7:0] next_cap_high;
   logic [7:0] next_cnt_low;
   logic [7:0] next_cnt_high;
   logic [3:0] tick_cnt;
   logic ovf_pulse;

   // =============================================================
   // pin edges
   logic count_fall;
   logic trig_fall;
   tmr2_sync_edge u_count_edge (
      .clk(clk),
      .srst(srst),
      .pin(count_pin),
      .fall(count_fall)
   );
   tmr2_sync_edge u_trig_edge (
      .clk(clk),
      .srst(srst),
      .pin(trigger_pin),
      .fall(trig_fall)
   );

   // =============================================================
   // internal tick divider
   localparam logic [3:0] TICK_LAST = 4'(TICK_DIV - 1);
   wire tick = (tick_cnt == TICK_LAST);
   always_ff @(posedge clk) begin
      if (srst) tick_cnt <= 4'h0;
      else tick_cnt <= tick ? 4'h0 : tick_cnt + 4'h1;
   end

   // =============================================================
   // control field decode
   wire overflow_flag = timer_control[`TMR2_BIT_OVF];
   wire external_flag = timer_control[`TMR2_BIT_EXF];
   wire receive_baud_select = timer_control[`TMR2_BIT_RCLK];
   wire transmit_baud_select = timer_control[`TMR2_BIT_TRANSMIT_BAUD_SELECT];
   wire trigger_enable = timer_control[`TMR2_BIT_TRIGEN];
   wire run_bit = timer_control[`TMR2_BIT_RUN];
   wire source_select = timer_control[`TMR2_BIT_SRC];
   wire capture_reload_select = timer_control[`TMR2_BIT_CPRL];
   wire up_down_mode_bit = timer_mode[`TMR2_BIT_UPDOWN];
   wire baud_mode = receive_baud_select | transmit_baud_select;

   // =============================================================
   // count, overflow and trigger events
   wire [15:0] count = {count_high, count_low};
   wire [15:0] reload_val = {capture_reload_high, capture_reload_low};
   wire count_evt = run_bit & (source_select ? count_fall : tick);
   wire overflow = count_evt & (count == 16'hFFFF);
   wire trig_evt = trig_fall & trigger_enable & ~baud_mode;
   wire do_capture = trig_evt & capture_reload_select;
   // reload on overflow or trigger, forced in baud mode
   wire reload_mode = ~capture_reload_select | baud_mode;
   wire do_reload = (overflow & reload_mode)
      | (trig_evt & ~capture_reload_select);
   wire set_ovf = overflow & ~baud_mode;
   wire set_exf = trig_evt;

   // =============================================================
   // register write decode
   function automatic logic addr_is(input logic [7:0] a,
                                    input logic [7:0] want);
      addr_is = (a == want);
   endfunction : addr_is
   wire wr_ctl = sfr_req.wr & addr_is(sfr_req.addr, `TMR2_ADDR_CONTROL);
   wire bw_ctl = sfr_req.bit_wr & addr_is(sfr_req.addr, `TMR2_ADDR_CONTROL);
   wire wr_mode = sfr_req.wr & addr_is(sfr_req.addr, `TMR2_ADDR_MODE);
   wire wr_capl = sfr_req.wr & addr_is(sfr_req.addr, `TMR2_ADDR_CAP_LOW);
   wire wr_caph = sfr_req.wr & addr_is(sfr_req.addr, `TMR2_ADDR_CAP_HIGH);
   wire wr_cntl = sfr_req.wr & addr_is(sfr_req.addr, `TMR2_ADDR_CNT_LOW);
   wire wr_cnth = sfr_req.wr & addr_is(sfr_req.addr, `TMR2_ADDR_CNT_HIGH);

   // control: software write, then hardware sets win over clears
   logic [7:0] sw_control;
   always_comb begin
      sw_control = timer_control;
      if (wr_ctl) sw_control = sfr_req.wdata;
      else if (bw_ctl) sw_control[sfr_req.bit_sel] = sfr_req.bit_val;
      next_control = sw_control;
      if (set_ovf) next_control[`TMR2_BIT_OVF] = 1'b1;
      if (set_exf) next_control[`TMR2_BIT_EXF] = 1'b1;
   end

   // mode register holds only its low bit
   assign next_mode = wr_mode ? {7'h00, sfr_req.wdata[0]} : timer_mode;

   // capture pair: capture overrides a same-cycle write
   assign next_cap_low = do_capture ? count_low
      : (wr_capl ? sfr_req.wdata : capture_reload_low);
   assign next_cap_high = do_capture ? count_high
      : (wr_caph ? sfr_req.wdata : capture_reload_high);

   // count: reload, increment, then software byte writes
   logic [15:0] next_count;
   always_comb begin
      next_count = count;
      if (do_reload) next_count = reload_val;
      else if (count_evt) next_count = count + 16'h0001;
      if (wr_cntl) next_count[7:0] = sfr_req.wdata;
      if (wr_cnth) next_count[15:8] = sfr_req.wdata;
   end
   assign next_cnt_low = next_count[7:0];
   assign next_cnt_high = next_count[15:8];

   // =============================================================
   // register state
   always_ff @(posedge clk) begin
      if (srst) begin
         timer_control <= `TMR2_RST_CONTROL;
         timer_mode <= `TMR2_RST_MODE;
         capture_reload_low <= `TMR2_RST_BYTE;
         capture_reload_high <= `TMR2_RST_BYTE;
         count_low <= `TMR2_RST_BYTE;
         count_high <= `TMR2_RST_BYTE;
      end else begin
         timer_control <= next_control;
         timer_mode <= next_mode;
         capture_reload_low <= next_cap_low;
         capture_reload_high <= next_cap_high;
         count_low <= next_cnt_low;
         count_high <= next_cnt_high;
      end
   end

   // overflow pulse registered for the serial port
   always_ff @(posedge clk) begin
      if (srst) ovf_pulse <= 1'b0;
      else ovf_pulse <= overflow;
   end

   // =============================================================
   // read path
   always_ff @(posedge clk) begin
      if (srst) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_req.rd) begin
         unique case (sfr_req.addr)
            `TMR2_ADDR_CONTROL: sfr_rdata <= timer_control;
            `TMR2_ADDR_MODE: sfr_rdata <= timer_mode;
            `TMR2_ADDR_CAP_LOW: sfr_rdata <= capture_reload_low;
            `TMR2_ADDR_CAP_HIGH: sfr_rdata <= capture_reload_high;
            `TMR2_ADDR_CNT_LOW: sfr_rdata <= count_low;
            `TMR2_ADDR_CNT_HIGH: sfr_rdata <= count_high;
            default: sfr_rdata <= 8'h00;
         endcase
      end
   end
   assign sfr_hit = (sfr_req.addr >= `TMR2_ADDR_CONTROL)
      && (sfr_req.addr <= `TMR2_ADDR_CNT_HIGH);

   // =============================================================
   // baud clock selection and interrupt request
   always_ff @(posedge clk) begin
      if (srst) begin
         evt <= '0;
      end else begin
         evt.rx_baud_tick <= receive_baud_select ? ovf_pulse
            : timer1_overflow;
         evt.tx_baud_tick <= transmit_baud_select ? ovf_pulse
            : timer1_overflow;
         evt.irq <= timer_irq_enable & (overflow_flag
            | (external_flag & ~up_down_mode_bit));
      end
   end
endmodule : tmr2_counter
`default_nettype wire

// file: core/tmr2_params.svh
// constants for the timer 2 capture/reload counter
`ifndef TMR2_PARAMS_SVH
`define TMR2_PARAMS_SVH
// special function addresses
`define TMR2_ADDR_CONTROL 8'hC8
`define TMR2_ADDR_MODE 8'hC9
`define TMR2_ADDR_CAP_LOW 8'hCA
`define TMR2_ADDR_CAP_HIGH 8'hCB
`define TMR2_ADDR_CNT_LOW 8'hCC
`define TMR2_ADDR_CNT_HIGH 8'hCD
// control register bit positions
`define TMR2_BIT_OVF 7
`define TMR2_BIT_EXF 6
`define TMR2_BIT_RCLK 5
`define TMR2_BIT_TRANSMIT_BAUD_SELECT 4
`define TMR2_BIT_TRIGEN 3
`define TMR2_BIT_RUN 2
`define TMR2_BIT_SRC 1
`define TMR2_BIT_CPRL 0
// mode register bit positions
`define TMR2_BIT_UPDOWN 0
// reset values
`define TMR2_RST_CONTROL 8'h00
`define TMR2_RST_MODE 8'h00
`define TMR2_RST_BYTE 8'h00
// internal tick divider: one tick every twelve core clocks
`define TMR2_TICK_DIV 12
`endif

// file: core/tmr2_pkg.sv
// types for the timer 2 capture/reload counter
package tmr2_pkg;
   // special function register access from the core
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
      logic bit_wr;
      logic [2:0] bit_sel;
      logic bit_val;
   } tmr2_sfr_req_t;
   // events toward the serial port and interrupt logic
   typedef struct packed {
      logic rx_baud_tick;
      logic tx_baud_tick;
      logic irq;
   } tmr2_evt_t;
endpackage : tmr2_pkg

// file: core/tmr2_sync_edge.sv
// two-flop synchroniser with falling edge detector
`timescale 1ns/100ps
`default_nettype none
module tmr2_sync_edge (
   input wire logic clk,
   input wire logic srst,
   input wire logic pin,
   output logic fall
);
   logic meta;
   logic sync;
   logic last;
   // meta is read only by sync
   always_ff @(posedge clk) begin
      if (srst) begin
         meta <= 1'b1;
         sync <= 1'b1;
         last <= 1'b1;
      end else begin
         meta <= pin;
         sync <= meta;
         last <= sync;
      end
   end
   // high to low between two samples
   assign fall = last & ~sync;
endmodule : tmr2_sync_edge
`default_nettype wire

// file: sim/tmr2_counter_sva.sv
// port assertions for the timer 2 counter
`timescale 1ns/100ps
`default_nettype none
module tmr2_counter_sva (
   input wire logic clk,
   input wire logic srst,
   input wire tmr2_pkg::tmr2_sfr_req_t sfr_req,
   input wire logic [7:0] sfr_rdata,
   input wire logic sfr_hit,
   input wire logic timer_irq_enable,
   input wire tmr2_pkg::tmr2_evt_t evt
);
   // ======================
   // relations at the ports
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   AST_HIT: assert property (sfr_hit == (sfr_req.addr >= 8'hC8 && sfr_req.addr <= 8'hCD))
      else $error("hit flag wrong");
   AST_UNMAPPED: assert property (sfr_req.rd && !sfr_hit |=> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_HOLD: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
      else $error("read data moved");
   AST_MODE_RD: assert property (sfr_req.rd && sfr_req.addr == 8'hC9 |=> sfr_rdata[7:1] == 7'h00)
      else $error("mode upper bits set");
   AST_IRQ_GATE: assert property (!timer_irq_enable |=> !evt.irq)
      else $error("irq without enable");
   AST_IRQ_KEEP: assert property (evt.irq && timer_irq_enable && !$past(sfr_req.wr) && !$past(sfr_req.bit_wr) |=> evt.irq)
      else $error("irq dropped");
   AST_IRQ_FALL: assert property ($fell(evt.irq) |-> !$past(timer_irq_enable) || $past(sfr_req.wr, 2) || $past(sfr_req.bit_wr, 2))
      else $error("irq fell alone");
   AST_RESET_CLEAN: assert property ($fell(srst) |-> evt == '0 && sfr_rdata == 8'h00)
      else $error("outputs not clear");
endmodule : tmr2_counter_sva
bind tmr2_counter tmr2_counter_sva i_sva (.clk(clk), .srst(srst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .timer_irq_enable(timer_irq_enable), .evt(evt));
`default_nettype wire

// file: sim/tmr2_pin_model.sv
// count and trigger pins driven from outside
`timescale 1ns/100ps
`default_nettype none
module tmr2_pin_model (
   input wire logic clk,
   output logic count_pin,
   output logic trigger_pin
);
   // ======================
   // pulled up while idle
   initial begin
      count_pin = 1'b1;
      trigger_pin = 1'b1;
   end
   // one falling edge, long enough for the synchroniser
   task automatic fall(input logic sel);
      repeat (2) @(negedge clk);
      if (sel) trigger_pin = 1'b0;
      else count_pin = 1'b0;
      repeat (4) @(negedge clk);
      trigger_pin = 1'b1;
      count_pin = 1'b1;
      repeat (4) @(negedge clk);
   endtask : fall
endmodule : tmr2_pin_model
`default_nettype wire

// file: sim/tb_timer2_capture_reload_counter.sv
// testbench for the timer 2 counter
`timescale 1ns/100ps
`default_nettype none
module tb_timer2_capture_reload_counter;
   logic clk, srst, ten, t1o, cp, tp, rd_seen, hit;
   logic [7:0] rdata;
   logic [7:0] q[$];
   logic [15:0] r, e;
   tmr2_pkg::tmr2_sfr_req_t req;
   tmr2_pkg::tmr2_evt_t evt;
   int n_mismatch, comparisons, n_rx, n_tx;
   // ======================
   // clock, design, pins
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   tmr2_counter #(.TICK_DIV(3)) i_dut (.clk(clk), .srst(srst), .sfr_req(req), .sfr_rdata(rdata), .sfr_hit(hit), .timer_irq_enable(ten), .timer1_overflow(t1o), .count_pin(cp), .trigger_pin(tp), .evt(evt));
   tmr2_pin_model i_pins (.clk(clk), .count_pin(cp), .trigger_pin(tp));
   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      comparisons++;
      if (seen !== want) begin
         n_mismatch++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask : chk
   // one register access, op 1 write, 2 read, 3 bit write
   task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic [1:0] op, input logic [2:0] bs);
      @(negedge clk);
      req.addr = a;
      req.wdata = d;
      req.wr = (op == 2'h1);
      req.rd = (op == 2'h2);
      req.bit_wr = (op == 2'h3);
      req.bit_sel = bs;
      req.bit_val = d[0];
      @(negedge clk);
      req = '0;
   endtask : acc
   task automatic rx(input logic [7:0] a, input logic [7:0] want);
      q.push_back(want);
      acc(a, 8'h00, 2'h2, 3'h0);
   endtask : rx
   task automatic tally_and_finish;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   // watch read data and baud ticks
   always @(posedge clk) begin
      rd_seen <= req.rd;
      if (evt.rx_baud_tick === 1'b1) n_rx <= n_rx + 1;
      if (evt.tx_baud_tick === 1'b1) n_tx <= n_tx + 1;
   end
   always @(negedge clk) if (rd_seen === 1'b1) chk(rdata, q.pop_front());
   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      req = '0; srst = 1'b1; ten = 1'b0; t1o = 1'b0;
      n_mismatch = 0; comparisons = 0; n_rx = 0; n_tx = 0;
      void'($urandom(38));
      repeat (5) @(negedge clk);
      srst = 1'b0;
      ten = 1'($urandom); // random interrupt enable until the trigger test sets interrupt enable
      for (int a = 8'hC7; a <= 8'hCD; a++) rx(a[7:0], 8'h00);
      acc(8'hC9, 8'hFF, 2'h1, 3'h0);
      rx(8'hC9, 8'h01);
      acc(8'hC9, 8'h00, 2'h1, 3'h0);
      $display("test reset done");
      r = $urandom & 16'h7FFF;
      e = r + 16'h0001;
      acc(8'hCA, r[7:0], 2'h1, 3'h0);
      acc(8'hCB, r[15:8], 2'h1, 3'h0);
      acc(8'hCC, 8'hFE, 2'h1, 3'h0);
      acc(8'hCD, 8'hFF, 2'h1, 3'h0);
      acc(8'hC8, 8'h06, 2'h1, 3'h0);
      repeat (3) i_pins.fall(1'b0);
      acc(8'hC8, 8'h00, 2'h3, 3'h2);
      i_pins.fall(1'b0);
      rx(8'hCC, e[7:0]);
      rx(8'hCD, e[15:8]);
      rx(8'hC8, 8'h82);
      acc(8'hC8, 8'h02, 2'h1, 3'h0);
      rx(8'hC8, 8'h02);
      $display("test count done");
      acc(8'hC8, 8'h03, 2'h1, 3'h0);
      i_pins.fall(1'b1);
      rx(8'hCA, r[7:0]);
      ten = 1'b1;
      acc(8'hC8, 8'h0B, 2'h1, 3'h0);
      i_pins.fall(1'b1);
      rx(8'hCA, e[7:0]);
      rx(8'hCB, e[15:8]);
      rx(8'hC8, 8'h4B);
      chk({7'h00, evt.irq}, 8'h01);
      acc(8'hC9, 8'h01, 2'h1, 3'h0);
      repeat (2) @(negedge clk);
      chk({7'h00, evt.irq}, 8'h00);
      acc(8'hC8, 8'h0A, 2'h1, 3'h0);
      acc(8'hCA, 8'h00, 2'h1, 3'h0);
      i_pins.fall(1'b1);
      rx(8'hCC, 8'h00);
      rx(8'hC8, 8'h4A);
      $display("test trigger done");
      @(negedge clk) t1o = ~t1o;
      @(negedge clk) t1o = ~t1o;
      repeat (4) @(negedge clk);
      chk(n_rx[7:0], 8'h01);
      chk(n_tx[7:0], 8'h01);
      acc(8'hCC, 8'hFF, 2'h1, 3'h0);
      acc(8'hCD, 8'hFF, 2'h1, 3'h0);
      acc(8'hC8, 8'h37, 2'h1, 3'h0);
      @(negedge clk) t1o = ~t1o;
      @(negedge clk) t1o = ~t1o;
      i_pins.fall(1'b0);
      chk(n_rx[7:0], 8'h02);
      chk(n_tx[7:0], 8'h02);
      rx(8'hC8, 8'h37);
      rx(8'hCD, e[15:8]);
      $display("test baud done");
      tally_and_finish();
   end
endmodule : tb_timer2_capture_reload_counter
`default_nettype wire
